// ### design/data_sram_ecc_guard.sv
// Data SRAM SECDED guard with APB configuration, flag and fault address registers
`timescale 1ns/1ps
`default_nettype none
`include "data_sram_ecc_guard_consts.svh"
module data_sram_ecc_guard #(
	parameter int DEPTH = `ECC_DEPTH
) (
	input  wire logic                      CLK,         // System clock, 40 MHz
	input  wire logic                      RST,         // Async reset, active high
	input  wire data_sram_ecc_pkg::cpu_req_t CPU_REQ,   // CPU data memory request
	output logic [7:0]                     CPU_RDATA,   // Read byte, repaired
	output logic                           CPU_RVALID,  // Read data valid pulse
	input  wire logic                      PSEL,        // APB select
	input  wire logic                      PENABLE,     // APB enable
	input  wire logic                      PWRITE,      // APB direction
	input  wire logic [`ECC_PADDR_W-1:0]   PADDR,       // APB byte address
	input  wire logic [31:0]               PWDATA,      // APB write data
	output logic [31:0]                    PRDATA,      // APB read data
	output logic                           PREADY,      // APB ready
	output logic                           PSLVERR,     // APB unmapped address
	output logic                           IRQ          // Error interrupt level
);
	// Codeword positions 1..12 in word[11:0], overall parity in word[12]
	function automatic logic [3:0] syndrome(input logic [11:0] c);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 1; i <= 12; i++) begin
			if (c[i-1])
				s = s ^ 4'(i);
		end
		return s;
	endfunction : syndrome

	// Data bits sit at the non power-of-two positions
	function automatic logic [11:0] place(input logic [7:0] d);
		return {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
	endfunction : place

	function automatic logic [7:0] extract(input logic [11:0] c);
		return {c[11:8], c[6:4], c[2]};
	endfunction : extract

	// Five check bits generated per byte
	function automatic logic [12:0] encode(input logic [7:0] d);
		logic [11:0] c;
		logic [3:0]  s;
		c = place(d);
		s = syndrome(c);
		c[0] = s[0];
		c[1] = s[1];
		c[3] = s[2];
		c[7] = s[3];
		return {^c, c};
	endfunction : encode

	// Single flip repaired, double flip only flagged
	function automatic data_sram_ecc_pkg::dec_t decode(input logic [12:0] w);
		data_sram_ecc_pkg::dec_t r;
		logic [11:0] c;
		logic [3:0]  s;
		logic        p;
		c = w[11:0];
		s = syndrome(c);
		p = ^w;
		r.single = 1'b0;
		r.double = 1'b0;
		if (p) begin
			if (s > 4'hc)
				r.double = 1'b1;
			else begin
				r.single = 1'b1;
				if (s != 4'h0)
					c[s-4'h1] = ~c[s-4'h1];
			end
		end else if (s != 4'h0)
			r.double = 1'b1;
		r.data = extract(c);
		return r;
	endfunction : decode

	// Register index to select, printed offset times four
	function automatic data_sram_ecc_pkg::sel_t decode_addr(input logic [`ECC_PADDR_W-1:0] a);
		if (a == {`ECC_IDX_CFG, 2'b00})
			return data_sram_ecc_pkg::SEL_CFG;
		if (a == {`ECC_IDX_ADL, 2'b00} || a == {`ECC_IDX_ADH, 2'b00})
			return data_sram_ecc_pkg::SEL_ADR;
		return data_sram_ecc_pkg::SEL_NONE;
	endfunction : decode_addr

	logic [12:0]    mem [DEPTH];
	logic [12:0]    word_q;
	logic           rd_pend_q, rd_pend_d;
	logic [10:0]    rd_addr_q, rd_addr_d;
	logic [7:0]     rdata_q, rdata_d;
	logic           rvalid_q, rvalid_d;
	logic           en_q, en_d;
	logic           uie_q, uie_d;
	logic           cie_q, cie_d;
	logic           uflag_q, uflag_d;
	logic           cflag_q, cflag_d;
	logic [15:0]    fault_q, fault_d;
	logic           irq_q, irq_d;
	logic           pready_q, pready_d;
	logic           pslverr_q, pslverr_d;
	logic [31:0]    prdata_q, prdata_d;
	logic [12:0]    wword;
	logic           ue_ev, ce_ev;
	logic           wr_cfg, wr_adr;
	data_sram_ecc_pkg::dec_t dec;
	data_sram_ecc_pkg::sel_t sel;

	// Write path; with ECC off the byte is stored raw and checks are zero
	always_comb begin
		// Check bits made on every write while ECC is enabled
		wword = CPU_REQ.flip ^ (en_q ? encode(CPU_REQ.wdata) : {1'b0, place(CPU_REQ.wdata)});
		rd_pend_d = CPU_REQ.valid & ~CPU_REQ.we;
		rd_addr_d = rd_pend_q ? rd_addr_q : 11'h000;
		if (rd_pend_d)
			rd_addr_d = CPU_REQ.addr;
	end

	// Array and first read stage
	always_ff @(posedge CLK) begin
		if (CPU_REQ.valid & CPU_REQ.we)
			mem[CPU_REQ.addr] <= wword;
		if (rd_pend_d)
			word_q <= mem[CPU_REQ.addr];
	end

	// Second stage decodes the word read last cycle
	always_comb begin
		dec = decode(word_q);
		// Repaired byte returned, no software step
		rdata_d = rdata_q;
		if (rd_pend_q)
			rdata_d = en_q ? dec.data : extract(word_q[11:0]);
		rvalid_d = rd_pend_q;
		ue_ev = rd_pend_q & en_q & dec.double;
		ce_ev = rd_pend_q & en_q & dec.single;
	end

	// APB decode; zero wait state, ready rises in the first access cycle
	always_comb begin
		sel = decode_addr(PADDR);
		pready_d = PSEL & ~PENABLE;
		pslverr_d = PSEL & ~PENABLE & (sel == data_sram_ecc_pkg::SEL_NONE);
		prdata_d = 32'h0000_0000;
		if (PSEL & ~PENABLE & ~PWRITE) begin
			if (sel == data_sram_ecc_pkg::SEL_CFG)
				prdata_d = {24'h00_0000, en_q, 1'b0, uie_q, cie_q, 2'b00, uflag_q, cflag_q};
			else if (sel == data_sram_ecc_pkg::SEL_ADR)
				prdata_d = (PADDR == {`ECC_IDX_ADL, 2'b00}) ? {24'h00_0000, fault_q[7:0]}
					: {24'h00_0000, fault_q[15:8]};
		end
		wr_cfg = PSEL & PENABLE & pready_q & PWRITE & (sel == data_sram_ecc_pkg::SEL_CFG);
		wr_adr = PSEL & PENABLE & pready_q & PWRITE & (sel == data_sram_ecc_pkg::SEL_ADR);
	end

	// Configuration and flags; hardware set wins over a clearing write
	always_comb begin
		en_d = wr_cfg ? PWDATA[`ECC_BIT_EN] : en_q;
		uie_d = wr_cfg ? PWDATA[`ECC_BIT_UIE] : uie_q;
		cie_d = wr_cfg ? PWDATA[`ECC_BIT_CIE] : cie_q;
		// Zero clears, one leaves flag alone
		uflag_d = uflag_q & ~(wr_cfg & ~PWDATA[`ECC_BIT_UFLAG]);
		cflag_d = cflag_q & ~(wr_cfg & ~PWDATA[`ECC_BIT_CFLAG]);
		// Uncorrectable flag set only while ECC is enabled, regardless of its gate
		uflag_d = uflag_d | ue_ev;
		// Correctable flag set only while ECC is enabled, regardless of its gate
		cflag_d = cflag_d | ce_ev;
		// Capture only while no flag stands
		fault_d = fault_q;
		if ((ue_ev | ce_ev) & ~(uflag_q | cflag_q))
			fault_d = {5'h00, rd_addr_q};
		irq_d = (uflag_d & uie_d) | (cflag_d & cie_d);
	end

	// State registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			// Enable on, gates and flags off
			en_q <= 1'b1;
			uie_q <= 1'b0;
			cie_q <= 1'b0;
			uflag_q <= 1'b0;
			cflag_q <= 1'b0;
			fault_q <= 16'h0000;
			irq_q <= 1'b0;
			rd_pend_q <= 1'b0;
			rd_addr_q <= 11'h000;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			en_q <= en_d;
			uie_q <= uie_d;
			cie_q <= cie_d;
			uflag_q <= uflag_d;
			cflag_q <= cflag_d;
			fault_q <= fault_d;
			irq_q <= irq_d;
			rd_pend_q <= rd_pend_d;
			rd_addr_q <= rd_addr_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Outputs straight from flops
	assign CPU_RDATA = rdata_q;
	assign CPU_RVALID = rvalid_q;
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign IRQ = irq_q;

	// Checks on the design's own behaviour
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	a_read_latency: assert property (CPU_REQ.valid & ~CPU_REQ.we |-> ##2 CPU_RVALID)
		else $error("read data not returned two cycles after request");

	a_uflag_set: assert property (ue_ev |=> uflag_q)
		else $error("uncorrectable flag not set");

	a_cflag_set: assert property (ce_ev |=> cflag_q)
		else $error("correctable flag not set");

	a_flag_hold: assert property (uflag_q & ~(wr_cfg & ~PWDATA[1]) |=> uflag_q)
		else $error("uncorrectable flag lost without clearing write");

	// Address frozen under a standing flag
	a_addr_frozen: assert property (uflag_q | cflag_q |=> $stable(fault_q))
		else $error("fault address changed while flag set");

	// Address taken from the failing read
	a_addr_capture: assert property ((ue_ev | ce_ev) & ~(uflag_q | cflag_q)
		|=> fault_q == {5'h00, $past(rd_addr_q)})
		else $error("fault address not captured");

	a_irq_gate: assert property (IRQ == ((uflag_q & uie_q) | (cflag_q & cie_q)))
		else $error("interrupt does not match gated flags");

	a_addr_ro: assert property (wr_adr & ~ue_ev & ~ce_ev |=> $stable(fault_q))
		else $error("fault address changed by a write");
endmodule : data_sram_ecc_guard
`default_nettype wire

// ### pkg/data_sram_ecc_guard_consts.svh
// Offsets, field positions, reset values and sizes for the data SRAM ECC guard
`ifndef DATA_SRAM_ECC_GUARD_CONSTS_SVH
`define DATA_SRAM_ECC_GUARD_CONSTS_SVH
`define ECC_DEPTH        2048
`define ECC_AW           11
`define ECC_WORD_W       13
`define ECC_IDX_CFG      16'ha02d
`define ECC_IDX_ADL      16'ha02e
`define ECC_IDX_ADH      16'ha02f
`define ECC_PADDR_W      18
`define ECC_CFG_RESET    8'h80
`define ECC_BIT_EN       7
`define ECC_BIT_UIE      5
`define ECC_BIT_CIE      4
`define ECC_BIT_UFLAG    1
`define ECC_BIT_CFLAG    0
`endif

// ### pkg/data_sram_ecc_pkg.sv
// Types shared by the data SRAM ECC guard
package data_sram_ecc_pkg;
	typedef struct packed {
		logic        valid;
		logic        we;
		logic [10:0] addr;
		logic [7:0]  wdata;
		logic [12:0] flip;
	} cpu_req_t;
	typedef struct packed {
		logic [7:0] data;
		logic       single;
		logic       double;
	} dec_t;
	typedef enum logic [2:0] {
		SEL_NONE = 3'h1,
		SEL_CFG  = 3'h2,
		SEL_ADR  = 3'h4
	} sel_t;
endpackage : data_sram_ecc_pkg

// ### test/cpu_port_model.sv
// CPU data memory port model issuing byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module cpu_port_model (
	input  wire logic                   clk,    // System clock
	output var data_sram_ecc_pkg::cpu_req_t req, // Request to the guard
	input  wire logic [7:0]             rdata,  // Returned byte
	input  wire logic                   rvalid  // Read result pulse
);
	// Idle request from time zero
	initial req = '0;
	// One-cycle write; released fields are inverted so stale values never match
	task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic [12:0] f);
		req <= '{1'b1, 1'b1, a, d, f};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, ~d, ~f};
		@(posedge clk);
	endtask : wr
	// One-cycle read, then a bounded wait for the result pulse
	task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic ok);
		int n;
		req <= '{1'b1, 1'b0, a, 8'h00, 13'h0};
		@(posedge clk);
		req <= '{1'b0, 1'b1, ~a, 8'hff, 13'h1fff};
		ok = 1'b0;
		for (n = 0; n < 8 && ok !== 1'b1; n++) begin
			@(posedge clk);
			ok = (rvalid === 1'b1);
		end
		d = rdata;
	endtask : rd
endmodule : cpu_port_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the data SRAM ECC guard
`timescale 1ns/1ps
`default_nettype none
`include "data_sram_ecc_guard_consts.svh"
module tb_top;
	localparam logic [17:0] A_CFG = {`ECC_IDX_CFG, 2'b00};
	localparam logic [17:0] A_ADL = {`ECC_IDX_ADL, 2'b00};
	localparam logic [17:0] A_ADH = {`ECC_IDX_ADH, 2'b00};
	logic                        clk = 1'b0;
	logic                        rst = 1'b1;
	data_sram_ecc_pkg::cpu_req_t cpu_req;
	logic [7:0]                  rdata, d0, d1, rb;
	logic                        rvalid, pready, pslverr, irq, serr, ok;
	logic                        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [17:0]                 paddr = 18'h0;
	logic [31:0]                 pwdata = 32'h0, prdata, rv;
	logic [31:0]                 seed = 32'hd071f508;
	logic [10:0]                 a0, a1;
	int                          err_total = 0, num_checks = 0, b;
	// Free-running 25 ns clock
	always #12.5 clk = ~clk;
	data_sram_ecc_guard u_data_sram_ecc_guard (.CLK(clk), .RST(rst), .CPU_REQ(cpu_req), .CPU_RDATA(rdata),
		.CPU_RVALID(rvalid), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
	cpu_port_model u_cpu_port_model (.clk(clk), .req(cpu_req), .rdata(rdata), .rvalid(rvalid));
	// Xorshift source with a fixed start
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// Config readback: bits 6, 3 and 2 always read zero
	function logic [31:0] cfg_exp(input logic [7:0] v);
		return {24'h0, v & 8'hb3};
	endfunction : cfg_exp
	task automatic print_verdict();
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Setup, then access held until pready is sampled high
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			chk(32'h0, 32'h1);
			print_verdict();
		end
		rv = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Read a byte and compare; a missing result ends the run
	task automatic rdc(input logic [10:0] a, input logic [7:0] exp);
		u_cpu_port_model.rd(a, rb, ok);
		if (ok !== 1'b1) begin
			chk(32'h0, 32'h1);
			print_verdict();
		end
		chk({24'h0, rb}, {24'h0, exp});
	endtask : rdc
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, A_CFG, 32'h0);
		chk(rv, 32'h80);
		apb(1'b0, A_ADH, 32'h0);
		chk(rv, 32'h0);
		// Both boundary words first, then random ones
		for (int i = 0; i < 12; i++) begin
			a0 = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'(rnd());
			d0 = 8'(rnd());
			u_cpu_port_model.wr(a0, d0, 13'h0);
			rdc(a0, d0);
		end
		a0 = 11'(rnd());
		a1 = a0 ^ 11'h400;
		d0 = 8'(rnd());
		d1 = 8'(rnd());
		b = rnd() % 13;
		u_cpu_port_model.wr(a0, d0, 13'h1 << b);
		rdc(a0, d0);
		apb(1'b0, A_CFG, 32'h0);
		chk(rv, cfg_exp(8'h81));
		chk({31'h0, irq}, 32'h0);
		// Second fault while a flag stands: address must not move
		u_cpu_port_model.wr(a1, d1, (13'h1 << b) | (13'h1 << ((b + 1 + rnd() % 12) % 13)));
		u_cpu_port_model.rd(a1, rb, ok);
		chk({31'h0, ok}, 32'h1);
		apb(1'b0, A_CFG, 32'h0);
		chk(rv, cfg_exp(8'h83));
		apb(1'b0, A_ADL, 32'h0);
		chk(rv, {24'h0, a0[7:0]});
		apb(1'b1, A_CFG, 32'hff);
		chk({31'h0, serr}, 32'h0);
		apb(1'b0, A_CFG, 32'h0);
		chk(rv, cfg_exp(8'hb3));
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, A_ADH, 32'hff);
		chk({31'h0, serr}, 32'h0);
		apb(1'b0, A_ADH, 32'h0);
		chk(rv, {29'h0, a0[10:8]});
		apb(1'b0, 18'h0, 32'h0);
		chk({rv[30:0], serr}, 32'h1);
		apb(1'b1, A_CFG, 32'h90);
		chk({31'h0, irq}, 32'h0);
		u_cpu_port_model.wr(a0, d0, 13'h0);
		rdc(a0, d0);
		apb(1'b0, A_CFG, 32'h0);
		chk(rv, cfg_exp(8'h90));
		u_cpu_port_model.wr(a1, d1, 13'h1 << b);
		rdc(a1, d1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, A_ADL, 32'h0);
		chk(rv, {24'h0, a1[7:0]});
		// Mid-run reset with a flag standing and the interrupt high
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, A_CFG, 32'h0);
		chk(rv, 32'h80);
		apb(1'b0, A_ADL, 32'h0);
		chk(rv, 32'h0);
		// ECC off: flipped check and parity bits leave byte and flags alone
		apb(1'b1, A_CFG, 32'h0);
		u_cpu_port_model.wr(a0, d1, 13'h1081);
		rdc(a0, d1);
		apb(1'b0, A_CFG, 32'h0);
		chk(rv, 32'h0);
		// Back on: memory rewritten before it is trusted again
		apb(1'b1, A_CFG, 32'h80);
		u_cpu_port_model.wr(a0, d0, 13'h0);
		rdc(a0, d0);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
